// ===== verilog/tbk_pkg.sv
package tbk_pkg;

	// Register port widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets on the register port
	localparam logic [7:0] OFS_STATUS_CTRL = 8'hA0;
	localparam logic [7:0] OFS_CONTROL = 8'hA4;
	localparam logic [7:0] OFS_RELOAD_PRE = 8'hA3;
	localparam logic [7:0] OFS_RELOAD_BAUD0 = 8'hA9;
	localparam logic [7:0] OFS_RELOAD_BAUD1 = 8'hAB;
	localparam logic [7:0] OFS_RELOAD_BAUD2 = 8'hAD;
	localparam logic [7:0] OFS_RELOAD_BAUD3 = 8'hAF;

	// Fields of timer_bank_status_control
	localparam int BIT_GATE = 0;
	localparam int BIT_FLAG_PRE = 1;
	localparam int BIT_FLAG_BAUD0 = 4;

	// Fields of the control register
	localparam int BIT_LEVEL_LO = 0;
	localparam int BIT_SRC_BAUD0 = 4;

	// Reset values
	localparam logic RST_GATE = 1'b0;
	localparam logic [4:0] RST_FLAGS = 5'h00;
	localparam logic [4:0] RST_IRQ_EN = 5'h00;
	localparam logic [1:0] RST_LEVEL = 2'h0;
	localparam logic [3:0] RST_SRC = 4'h0;
	localparam logic [7:0] RST_RELOAD = 8'h00;
	localparam logic [7:0] RST_COUNT = 8'h00;

	// Timing: peripheral clock and the halved base clock of the bank
	localparam int CLK_PERIOD_NS = 10;
	localparam int BASE_PERIOD_NS = 20;
	localparam int BASE_DIV_CYC = (BASE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Interrupt level codes
	typedef enum logic [1:0] {
		TBK_LVL_OFF = 2'h0,
		TBK_LVL_1 = 2'h1,
		TBK_LVL_2 = 2'h2,
		TBK_LVL_3 = 2'h3
	} tbk_level_e;

	// One register port request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} tbk_bus_s;

endpackage

// ===== verilog/tbk_base_div.sv
module tbk_base_div #(
	parameter int DIV = tbk_pkg::BASE_DIV_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic gate,
	output logic tick
);

	logic [7:0] phase_q;

	// Phase restarts whenever the gate is off so the first tick after enabling is a full base period away
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			phase_q <= 8'h00;
		else if (ce)
		begin
			if (!gate || phase_q == 8'(DIV - 1))
				phase_q <= 8'h00;
			else
				phase_q <= phase_q + 8'h01;
		end
	end

	// One clk-wide strobe per base period, marking the trailing edge of a base pulse
	assign tick = ce && gate && (phase_q == 8'(DIV - 1));

endmodule

// ===== verilog/tbk_countdown.sv
module tbk_countdown #(
	parameter int W = 8,
	parameter int PULSE_CYC = tbk_pkg::BASE_DIV_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic in_tick,
	input wire logic [W-1:0] reload,
	output logic out_tick,
	output logic out_pulse
);

	logic [W-1:0] count_q;
	logic [7:0] width_q;
	logic at_zero;

	assign at_zero = (count_q == '0);

	// Count moves only when an input pulse ends, the trailing edge of the incoming base pulse
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			count_q <= W'(tbk_pkg::RST_COUNT);
		else if (ce && in_tick)
		begin
			if (at_zero)
				count_q <= reload; // reload is sampled live, so a fresh write shapes the next period
			else
				count_q <= count_q - W'(1);
		end
	end

	// Event strobe to the cascade and status logic, one clk wide, at the reloading input pulse
	assign out_tick = ce && in_tick && at_zero;

	// Visible pulse stretched to one base clock period
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			width_q <= 8'h00;
		else if (ce)
		begin
			if (out_tick)
				width_q <= 8'(PULSE_CYC);
			else if (width_q != 8'h00)
				width_q <= width_q - 8'h01;
		end
	end

	assign out_pulse = (width_q != 8'h00);

endmodule

// ===== verilog/tbk_timer_bank.sv
// The register addresses and the plain strobed port were left to the implementer.
module tbk_timer_bank #(
	parameter int CNT_W = 8,
	parameter int N_BAUD = 4
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire tbk_pkg::tbk_bus_s bus,
	output logic [7:0] rdata,
	output logic prescaler_pulse,
	output logic [N_BAUD-1:0] baud_clk,
	output logic irq,
	output tbk_pkg::tbk_level_e irq_level
);

	// Software state
	logic gate_q;
	logic [N_BAUD:0] irq_en_q;
	logic [1:0] level_q;
	logic [N_BAUD-1:0] src_q;
	logic [CNT_W-1:0] reload_pre_q;
	logic [CNT_W-1:0] reload_baud_q [N_BAUD];

	// Event state
	logic [N_BAUD:0] flag_q;
	logic [N_BAUD:0] flag_d;
	logic [7:0] rdata_q;

	// Internal strobes
	logic base_tick;
	logic pre_tick;
	logic [N_BAUD-1:0] baud_in_tick;
	logic [N_BAUD-1:0] baud_tick;
	logic [N_BAUD:0] events;
	logic status_read;
	logic status_write;
	logic control_write;

	// Address of the reload register of baud timer idx; used by the write path only, the read decode ignores it
	function automatic logic [7:0] baud_reload_ofs(input int idx);
		logic [7:0] ofs;
		case (idx)
			0: ofs = tbk_pkg::OFS_RELOAD_BAUD0;
			1: ofs = tbk_pkg::OFS_RELOAD_BAUD1;
			2: ofs = tbk_pkg::OFS_RELOAD_BAUD2;
			3: ofs = tbk_pkg::OFS_RELOAD_BAUD3;
			default: ofs = tbk_pkg::OFS_RELOAD_PRE;
		endcase
		return ofs;
	endfunction

	// Status byte as software sees it; bits 2 and 3 and the write-only gate read as zero
	function automatic logic [7:0] status_image(input logic [N_BAUD:0] flags);
		logic [7:0] img;
		img = 8'h00;
		img[tbk_pkg::BIT_FLAG_PRE] = flags[0];
		for (int i = 0; i < N_BAUD; i++)
			img[tbk_pkg::BIT_FLAG_BAUD0 + i] = flags[i + 1];
		return img;
	endfunction

	// Strobe decode; a strobe that meets a low clock enable is dropped
	assign status_read = ce && bus.rd && (bus.addr == tbk_pkg::OFS_STATUS_CTRL);
	assign status_write = ce && bus.wr && (bus.addr == tbk_pkg::OFS_STATUS_CTRL);
	assign control_write = ce && bus.wr && (bus.addr == tbk_pkg::OFS_CONTROL);

	// Clock gate and interrupt enables share one write
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			gate_q <= tbk_pkg::RST_GATE;
			irq_en_q <= (N_BAUD + 1)'(tbk_pkg::RST_IRQ_EN);
		end
		else if (status_write)
		begin
			gate_q <= bus.wdata[tbk_pkg::BIT_GATE];
			irq_en_q[0] <= bus.wdata[tbk_pkg::BIT_FLAG_PRE];
			irq_en_q[N_BAUD:1] <= bus.wdata[tbk_pkg::BIT_FLAG_BAUD0 +: N_BAUD];
		end
	end

	// Interrupt level and baud source selects
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			level_q <= tbk_pkg::RST_LEVEL;
			src_q <= N_BAUD'(tbk_pkg::RST_SRC);
		end
		else if (control_write)
		begin
			level_q <= bus.wdata[tbk_pkg::BIT_LEVEL_LO +: 2];
			src_q <= bus.wdata[tbk_pkg::BIT_SRC_BAUD0 +: N_BAUD];
		end
	end

	// Prescaler reload; writes land at once, even mid-count
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			reload_pre_q <= CNT_W'(tbk_pkg::RST_RELOAD);
		else if (ce && bus.wr && bus.addr == tbk_pkg::OFS_RELOAD_PRE)
			reload_pre_q <= bus.wdata[CNT_W-1:0];
	end

	// Base pulse stream at half the peripheral clock, stopped while the gate is off
	tbk_base_div #(
		.DIV(tbk_pkg::BASE_DIV_CYC)
	) u_base (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.gate(gate_q),
		.tick(base_tick)
	);

	// Prescaler timer, always fed from the base stream
	tbk_countdown #(
		.W(CNT_W),
		.PULSE_CYC(tbk_pkg::BASE_DIV_CYC)
	) u_prescaler (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.in_tick(base_tick),
		.reload(reload_pre_q),
		.out_tick(pre_tick),
		.out_pulse(prescaler_pulse)
	);

	// Baud timers; timer i drives serial port i, A first
	generate
		for (genvar i = 0; i < N_BAUD; i++)
		begin : g_baud
			// Reload register of this timer
			always_ff @(posedge clk or negedge nrst)
			begin
				if (!nrst)
					reload_baud_q[i] <= CNT_W'(tbk_pkg::RST_RELOAD);
				else if (ce && bus.wr && bus.addr == baud_reload_ofs(i))
					reload_baud_q[i] <= bus.wdata[CNT_W-1:0];
			end

			// Cascade select; prescaler events only exist while the gate is on, so gating still holds
			assign baud_in_tick[i] = src_q[i] ? pre_tick : base_tick;

			tbk_countdown #(
				.W(CNT_W),
				.PULSE_CYC(tbk_pkg::BASE_DIV_CYC)
			) u_baud (
				.clk(clk),
				.nrst(nrst),
				.ce(ce),
				.in_tick(baud_in_tick[i]),
				.reload(reload_baud_q[i]),
				.out_tick(baud_tick[i]),
				.out_pulse(baud_clk[i])
			);
		end
	endgenerate

	assign events = {baud_tick, pre_tick};

	// Read clears every flag, but an event in the same cycle is set again so it is never lost
	always_comb
	begin
		flag_d = flag_q;
		if (status_read)
			flag_d = '0;
		flag_d = flag_d | events;
	end

	// Sticky terminal-count flags
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			flag_q <= (N_BAUD + 1)'(tbk_pkg::RST_FLAGS);
		else if (ce)
			flag_q <= flag_d;
	end

	// Read data, valid the cycle after the read strobe and zero otherwise
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rdata_q <= 8'h00;
		else if (ce)
		begin
			if (status_read)
				rdata_q <= status_image(flag_q);
			else
				rdata_q <= 8'h00; // Other registers are write-only; unmapped reads also give zero
		end
	end

	assign rdata = rdata_q;

	// Single request for the whole bank; it follows the flags, so a flag cleared by a read drops it
	assign irq = (level_q != 2'h0) && |(flag_q & irq_en_q);
	assign irq_level = tbk_pkg::tbk_level_e'(level_q);

endmodule

// ===== tb/tbk_chk.sv
module tbk_chk #(
	parameter int N_BAUD = 4
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire tbk_pkg::tbk_bus_s bus,
	input wire logic [7:0] rdata,
	input wire logic prescaler_pulse,
	input wire logic [N_BAUD-1:0] baud_clk,
	input wire logic irq,
	input wire tbk_pkg::tbk_level_e irq_level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic gate_q;
	logic en_q;
	wire logic any_rd = ce && bus.rd;
	wire logic st_rd = any_rd && bus.addr == tbk_pkg::OFS_STATUS_CTRL;
	wire logic st_wr = ce && bus.wr && bus.addr == tbk_pkg::OFS_STATUS_CTRL;
	wire logic [1:0] lvl_in = bus.wdata[1:0];
	// Shadow of gate and prescaler interrupt enable, so checks need no peek inside
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			gate_q <= 1'b0;
			en_q <= 1'b0;
		end
		else if (st_wr)
		begin
			gate_q <= bus.wdata[0];
			en_q <= bus.wdata[1];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	pulse_len_a: assert property ($rose(prescaler_pulse) |=> prescaler_pulse)
		else $error("pulse too short");
	pulse_gap_a: assert property ($rose(prescaler_pulse) |=> !$rose(prescaler_pulse) [*3])
		else $error("pulses closer than base rate");
	rd_idle_a: assert property (!$past(any_rd) |-> rdata == 8'h00)
		else $error("read data outside read slot");
	gate_off_a: assert property (!gate_q [*2] |-> !$rose(prescaler_pulse) && !$rose(baud_clk[0]))
		else $error("pulse with gate off");
	lvl_copy_a: assert property (ce && bus.wr && bus.addr == tbk_pkg::OFS_CONTROL |=> irq_level == $past(lvl_in))
		else $error("level not taken");
	irq_off_a: assert property (irq_level == tbk_pkg::TBK_LVL_OFF |-> !irq)
		else $error("request at level off");
	irq_raise_a: assert property ($rose(prescaler_pulse) && en_q && irq_level != tbk_pkg::TBK_LVL_OFF |-> irq)
		else $error("enabled event gave no request");
	irq_clear_a: assert property (st_rd ##1 !(prescaler_pulse || (|baud_clk)) |-> !irq)
		else $error("request after clearing read");
endmodule

// ===== tb/tbk_port_model.sv
module tbk_port_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [3:0] baud_clk,
	output logic [3:0][15:0] edges
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] prev_q;
	// Ports A to D each count rising edges of their own baud clock
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			prev_q <= 4'h0;
			edges <= '0;
		end
		else
		begin
			prev_q <= baud_clk;
			for (int i = 0; i < 4; i++)
				if (baud_clk[i] && !prev_q[i])
					edges[i] <= edges[i] + 16'h0001;
		end
	end
endmodule

// ===== tb/tb_tbk_timer_bank.sv
module tb_tbk_timer_bank;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] SC = tbk_pkg::OFS_STATUS_CTRL;
	localparam logic [7:0] CT = tbk_pkg::OFS_CONTROL;
	localparam logic [7:0] RA [5] = '{8'hA3, 8'hA9, 8'hAB, 8'hAD, 8'hAF};
	logic clk;
	logic nrst;
	logic ce;
	tbk_pkg::tbk_bus_s bus;
	logic [7:0] rdata;
	logic prescaler_pulse;
	logic [3:0] baud_clk;
	logic irq;
	tbk_pkg::tbk_level_e irq_level;
	logic [3:0][15:0] edges;
	wire logic [4:0] sig = {baud_clk, prescaler_pulse};
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	// Reload beside its period in clocks when fed from the base
	logic [7:0] rl [4] = '{8'h01, 8'h03, 8'h0A, 8'hFF};
	logic [31:0] per [4] = '{32'h4, 32'h8, 32'h16, 32'h200};
	tbk_timer_bank u_tbk_timer_bank (.clk(clk), .nrst(nrst), .ce(ce), .bus(bus), .rdata(rdata),
		.prescaler_pulse(prescaler_pulse), .baud_clk(baud_clk), .irq(irq), .irq_level(irq_level));
	tbk_port_model u_tbk_port_model (.clk(clk), .nrst(nrst), .baud_clk(baud_clk), .edges(edges));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// A gap cycle after each access keeps one assignment per time step
	task wr(input logic [7:0] a, input logic [7:0] d);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input logic [7:0] a, output logic [7:0] v);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		@(posedge clk);
		v = rdata;
	endtask
	task rl_all(input logic [7:0] r);
		foreach (RA[i])
			wr(RA[i], r);
	endtask
	// Clocks between two rising edges; the first rise already uses the new reload
	task meas(input int k, input logic [31:0] e);
		int n;
		int r;
		logic p;
		n = 0;
		r = 0;
		p = 1'b1;
		while (r < 2 && n < 4000)
		begin
			@(posedge clk);
			n++;
			if (sig[k] && !p)
			begin
				r++;
				if (r == 1)
					n = 0;
			end
			p = sig[k];
		end
		chk(n, e);
	endtask
	task stop_test();
		$display("Checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			err_total++;
			stop_test();
		end
	end
	initial
	begin
		logic [7:0] v;
		int s;
		int c;
		nrst = 1'b0;
		ce = 1'b1;
		bus = '0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		repeat (20) @(posedge clk);
		rd(SC, v);
		chk(v, 8'h00);
		chk(edges[0], 16'h0000);
		rd(RA[0], v);
		chk(v, 8'h00);
		rd(8'h55, v);
		chk(v, 8'h00);
		$display("test reset done");
		wr(SC, 8'h01);
		foreach (rl[i])
		begin
			rl_all(rl[i]);
			for (int k = 0; k < 5; k++)
				meas(k, per[i]);
		end
		wr(CT, 8'h10);
		wr(RA[0], 8'h02);
		wr(RA[1], 8'h01);
		meas(1, 32'hC);
		wr(CT, 8'h00);
		wr(RA[1], 8'h00);
		repeat (20) @(posedge clk);
		repeat (6)
		begin
			@(posedge clk);
			chk(baud_clk[0], 1'b1);
		end
		$display("test periods done");
		wr(SC, 8'hF2);
		repeat (4) @(posedge clk);
		rd(SC, v);
		rd(SC, v);
		chk(v, 8'h00);
		for (int l = 0; l < 4; l++)
		begin
			wr(CT, l[7:0]);
			chk(irq_level, l);
		end
		rl_all(8'h01);
		wr(SC, 8'hF3);
		// Long enough for a counter left near 255 to reach its first reload
		repeat (600) @(posedge clk);
		wr(SC, 8'hF2);
		repeat (4) @(posedge clk);
		chk(irq, 1'b1);
		wr(CT, 8'h00);
		chk(irq, 1'b0);
		wr(CT, 8'h01);
		rd(SC, v);
		chk(v, 8'hF2);
		chk(irq, 1'b0);
		wr(SC, 8'h01);
		repeat (40) @(posedge clk);
		wr(SC, 8'h00);
		repeat (4) @(posedge clk);
		chk(irq, 1'b0);
		s = edges[0];
		repeat (40) @(posedge clk);
		chk(edges[0], s);
		rd(SC, v);
		chk(v, 8'hF2);
		$display("test interrupts done");
		wr(RA[1], 8'h03);
		s = edges[0];
		c = 0;
		wr(SC, 8'h01);
		repeat (60)
		begin
			rd(SC, v);
			c += v[4];
		end
		wr(SC, 8'h00);
		repeat (4) @(posedge clk);
		rd(SC, v);
		c += v[4];
		chk(c, edges[0] - s);
		// A write that meets a low clock enable must be dropped
		ce <= 1'b0;
		wr(CT, 8'h02);
		ce <= 1'b1;
		chk(irq_level, 1);
		$display("test events done");
		stop_test();
	end
endmodule
bind tbk_timer_bank tbk_chk #(.N_BAUD(N_BAUD)) u_tbk_chk (.clk(clk), .nrst(nrst), .ce(ce), .bus(bus),
	.rdata(rdata), .prescaler_pulse(prescaler_pulse), .baud_clk(baud_clk), .irq(irq), .irq_level(irq_level));
